/* design/pmr_consts.svh */
// Purpose: constants for the management register set
// Assumes: 16-bit registers at word offsets 0x00..0x04
// Notes: included by the design files and the bench
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMR_OFS_CONTROL 5'h00
`define PMR_OFS_STATUS 5'h01
`define PMR_OFS_ID_LOW 5'h02
`define PMR_OFS_ID_HIGH 5'h03
`define PMR_OFS_ADVERT 5'h04

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define PMR_CTL_SWRESET 15
`define PMR_CTL_LOOPBACK 14
`define PMR_CTL_SPEED_MSB 6
`define PMR_CTL_SPEED_LSB 13
`define PMR_CTL_ANEG_EN 12
`define PMR_CTL_PWRDOWN 11
`define PMR_CTL_RESTART 9
`define PMR_CTL_DUPLEX 8
`define PMR_CTL_COLTEST 7

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define PMR_STA_ANEG_DONE 5
`define PMR_STA_FAULT 4
`define PMR_STA_LINK 2
`define PMR_STA_JABBER 1

// ----------------------------------------
// Reset values and fixed patterns
// ----------------------------------------
`define PMR_CONTROL_RESET 16'h1140
`define PMR_CONTROL_WMASK 16'h79C0
`define PMR_ADVERT_RESET 16'h0DE1
`define PMR_ADVERT_WMASK 16'hBFFF
`define PMR_STATUS_FIXED 16'h7949

// ----------------------------------------
// Identity fields, values arbitrary
// ----------------------------------------
`define PMR_OUI_LOW 16'h1234
`define PMR_OUI_HIGH 6'h2A
`define PMR_MODEL 6'h15
`define PMR_REVISION 4'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMR_CLK_PERIOD_NS 4
`define PMR_COL_RISE_BITS 512
`define PMR_COL_FALL_BITS 4
`define PMR_RESET_HOLD_CYC 4'h8

`endif

/* design/pmr_pkg.sv */
// Purpose: types for the management register set
// Assumes: nothing
// Notes: constants live in pmr_consts.svh
package pmr_pkg;

    typedef enum logic [1:0] {
        PMR_SPD_10 = 2'b00,
        PMR_SPD_100 = 2'b01,
        PMR_SPD_1000 = 2'b10,
        PMR_SPD_RSVD = 2'b11
    } pmr_speed_t;

    typedef enum logic [1:0] {
        PMR_AN_IDLE = 2'b00,
        PMR_AN_DETECT = 2'b01,
        PMR_AN_WAIT = 2'b10,
        PMR_AN_DONE = 2'b11
    } pmr_aneg_state_t;

endpackage : pmr_pkg

/* design/pmr_colltest.sv */
// Purpose: collision test driver for COL
// Assumes: tx enable synchronous to clock_in
// Notes: COL rises one cycle after TX_EN, well inside the allowed time
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"

module pmr_colltest (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic tx_en_in,
    output logic col_out
);
    logic col_reg;

    // ----------------------------------------
    // Collision follow
    // ----------------------------------------
    // One cycle equals 4 bit times at gigabit rate, far below 512 bit times
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            col_reg <= 1'b0;
        end else begin
            col_reg <= enable_in & tx_en_in;
        end
    end

    assign col_out = col_reg;

    col_follow_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (enable_in && tx_en_in) |=> col_reg) else $error("col not raised");
    col_drop_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !tx_en_in |=> !col_reg) else $error("col not dropped");

endmodule : pmr_colltest
`default_nettype wire

/* design/pmr_regs.sv */
// Purpose: management control, status and identifier registers
// Assumes: register port: addr, wr strobe, rd strobe, 16-bit data
// Notes: read data registered, valid one cycle after rd strobe
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"

module pmr_regs
    import pmr_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic sticky_keep_in,
    input wire logic link_pass_in,
    input wire logic far_fault_in,
    input wire logic jabber_in,
    input wire logic aneg_ack_in,
    input wire logic tx_en_in,
    input wire logic [7:0] txd_in,
    input wire logic [7:0] line_rxd_in,
    input wire logic line_rx_dv_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [7:0] rxd_out,
    output logic rx_dv_out,
    output logic [7:0] line_txd_out,
    output logic line_tx_en_out,
    output logic col_out,
    output logic [1:0] speed_out,
    output logic full_duplex_out,
    output logic power_down_out,
    output logic aneg_start_out,
    output logic [15:0] advert_latched_out
);
    logic [15:0] control_reg;
    logic [15:0] advert_reg;
    logic [15:0] advert_lat_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic fault_reg;
    logic link_reg;
    logic jabber_reg;
    logic soft_rst_reg;
    logic [3:0] rst_cnt_reg;
    pmr_aneg_state_t an_state_reg;
    logic aneg_start_reg;
    logic [1:0] speed_reg;
    logic duplex_reg;
    logic pwr_reg;
    logic [7:0] rxd_reg;
    logic rx_dv_reg;
    logic [7:0] ltxd_reg;
    logic ltx_en_reg;
    logic col_int;
    logic wr_ctl;
    logic rd_sta;
    logic restart;
    logic [15:0] status_word;
    logic [15:0] id_high;

    assign wr_ctl = reg_wr_in && (reg_addr_in == `PMR_OFS_CONTROL);
    assign rd_sta = reg_rd_in && (reg_addr_in == `PMR_OFS_STATUS);
    assign restart = wr_ctl && reg_wdata_in[`PMR_CTL_RESTART];
    assign id_high = {`PMR_OUI_HIGH, `PMR_MODEL, `PMR_REVISION};

    // ----------------------------------------
    // Software reset hold
    // ----------------------------------------
    // Soft reset held a few cycles so every consumer sees it
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rst_cnt_reg <= 4'h0;
            soft_rst_reg <= 1'b0;
        end else if (wr_ctl && reg_wdata_in[`PMR_CTL_SWRESET]) begin
            rst_cnt_reg <= `PMR_RESET_HOLD_CYC;
            soft_rst_reg <= 1'b1;
        end else if (rst_cnt_reg != 4'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
            soft_rst_reg <= 1'b1;
        end else begin
            soft_rst_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // Bits 15 and 9 never stored, so they always read zero
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            control_reg <= `PMR_CONTROL_RESET;
        end else if (wr_ctl && reg_wdata_in[`PMR_CTL_SWRESET]) begin
            control_reg <= `PMR_CONTROL_RESET;
        end else if (wr_ctl) begin
            control_reg <= reg_wdata_in & `PMR_CONTROL_WMASK;
        end
    end

    // ----------------------------------------
    // Advertisement register and its sample
    // ----------------------------------------
    // Advertisement is the reset-sticky register here
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            advert_reg <= `PMR_ADVERT_RESET;
        end else if (wr_ctl && reg_wdata_in[`PMR_CTL_SWRESET] && !sticky_keep_in) begin
            advert_reg <= `PMR_ADVERT_RESET;
        end else if (reg_wr_in && (reg_addr_in == `PMR_OFS_ADVERT)) begin
            advert_reg <= reg_wdata_in & `PMR_ADVERT_WMASK;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            advert_lat_reg <= `PMR_ADVERT_RESET;
        end else if (an_state_reg == PMR_AN_IDLE && control_reg[`PMR_CTL_ANEG_EN]
                     && !soft_rst_reg && !pwr_reg) begin
            advert_lat_reg <= advert_reg;
        end
    end

    // ----------------------------------------
    // Negotiation sequencer
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            an_state_reg <= PMR_AN_IDLE;
            aneg_start_reg <= 1'b0;
        end else begin
            aneg_start_reg <= 1'b0;
            // Turning negotiation off drops done at the same edge as the write
            if (soft_rst_reg || pwr_reg || !control_reg[`PMR_CTL_ANEG_EN] || restart
                || (wr_ctl && !reg_wdata_in[`PMR_CTL_ANEG_EN])) begin
                an_state_reg <= PMR_AN_IDLE;
            end else begin
                unique case (an_state_reg)
                    PMR_AN_IDLE: begin
                        an_state_reg <= PMR_AN_DETECT;
                        aneg_start_reg <= 1'b1;
                    end
                    PMR_AN_DETECT: begin
                        an_state_reg <= PMR_AN_WAIT;
                    end
                    PMR_AN_WAIT: begin
                        if (aneg_ack_in) begin
                            an_state_reg <= PMR_AN_DONE;
                        end
                    end
                    PMR_AN_DONE: begin
                        an_state_reg <= PMR_AN_DONE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Operating mode
    // ----------------------------------------
    // Negotiated result assumed gigabit full duplex; host keeps AN on there
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            speed_reg <= PMR_SPD_1000;
            duplex_reg <= 1'b1;
            pwr_reg <= 1'b0;
        end else begin
            pwr_reg <= control_reg[`PMR_CTL_PWRDOWN];
            if (!control_reg[`PMR_CTL_ANEG_EN] || control_reg[`PMR_CTL_LOOPBACK]) begin
                speed_reg <= {control_reg[`PMR_CTL_SPEED_MSB],
                              control_reg[`PMR_CTL_SPEED_LSB]};
            end else begin
                speed_reg <= PMR_SPD_1000;
            end
            if (!control_reg[`PMR_CTL_ANEG_EN]) begin
                duplex_reg <= control_reg[`PMR_CTL_DUPLEX];
            end else begin
                duplex_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Latched status bits
    // ----------------------------------------
    // Event wins over the read that would clear it
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fault_reg <= 1'b0;
            jabber_reg <= 1'b0;
            link_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            fault_reg <= 1'b0;
            jabber_reg <= 1'b0;
            link_reg <= 1'b0;
        end else begin
            if (far_fault_in) begin
                fault_reg <= 1'b1;
            end else if (rd_sta) begin
                fault_reg <= 1'b0;
            end
            if (jabber_in && speed_reg == PMR_SPD_10) begin
                jabber_reg <= 1'b1;
            end else if (rd_sta) begin
                jabber_reg <= 1'b0;
            end
            if (!link_pass_in) begin
                link_reg <= 1'b0;
            end else if (rd_sta) begin
                link_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        status_word = `PMR_STATUS_FIXED;
        status_word[`PMR_STA_ANEG_DONE] = (an_state_reg == PMR_AN_DONE);
        status_word[`PMR_STA_FAULT] = fault_reg;
        status_word[`PMR_STA_LINK] = link_reg;
        status_word[`PMR_STA_JABBER] = jabber_reg;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped offsets read zero
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_in;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    `PMR_OFS_CONTROL: rdata_reg <= control_reg;
                    `PMR_OFS_STATUS: rdata_reg <= status_word;
                    `PMR_OFS_ID_LOW: rdata_reg <= `PMR_OUI_LOW;
                    `PMR_OFS_ID_HIGH: rdata_reg <= id_high;
                    `PMR_OFS_ADVERT: rdata_reg <= advert_reg;
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Data path and loopback
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rxd_reg <= 8'h00;
            rx_dv_reg <= 1'b0;
            ltxd_reg <= 8'h00;
            ltx_en_reg <= 1'b0;
        end else if (control_reg[`PMR_CTL_LOOPBACK]) begin
            rxd_reg <= txd_in;
            rx_dv_reg <= tx_en_in;
            ltxd_reg <= 8'h00;
            ltx_en_reg <= 1'b0;
        end else begin
            rxd_reg <= line_rxd_in;
            rx_dv_reg <= line_rx_dv_in;
            ltxd_reg <= txd_in;
            ltx_en_reg <= tx_en_in & ~pwr_reg;
        end
    end

    pmr_colltest u_colltest (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(control_reg[`PMR_CTL_COLTEST]),
        .tx_en_in(tx_en_in),
        .col_out(col_int)
    );

    assign reg_rdata_out = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;
    assign rxd_out = rxd_reg;
    assign rx_dv_out = rx_dv_reg;
    assign line_txd_out = ltxd_reg;
    assign line_tx_en_out = ltx_en_reg;
    assign col_out = col_int;
    assign speed_out = speed_reg;
    assign full_duplex_out = duplex_reg;
    assign power_down_out = pwr_reg;
    assign aneg_start_out = aneg_start_reg;
    assign advert_latched_out = advert_lat_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sc_bits_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !control_reg[`PMR_CTL_SWRESET] && !control_reg[`PMR_CTL_RESTART])
        else $error("self-clearing bit stored");
    swrst_default_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (wr_ctl && reg_wdata_in[`PMR_CTL_SWRESET]) |=> control_reg == `PMR_CONTROL_RESET)
        else $error("soft reset not applied");
    loop_silent_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        control_reg[`PMR_CTL_LOOPBACK] |=> !ltx_en_reg && rx_dv_reg == $past(tx_en_in))
        else $error("loopback leaked");
    forced_speed_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !control_reg[`PMR_CTL_ANEG_EN] |=> speed_reg == {$past(control_reg[6]),
        $past(control_reg[13])}) else $error("forced speed wrong");
    restart_idle_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        restart |=> an_state_reg == PMR_AN_IDLE) else $error("restart missed");
    duplex_ign_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        control_reg[`PMR_CTL_ANEG_EN] |=> duplex_reg) else $error("duplex not ignored");
    link_fail_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !link_pass_in |=> !link_reg) else $error("link not latched low");
    jabber_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (jabber_reg && !rd_sta && !soft_rst_reg) |=> jabber_reg)
        else $error("jabber lost");
    aneg_done_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        status_word[`PMR_STA_ANEG_DONE] |-> control_reg[`PMR_CTL_ANEG_EN])
        else $error("done without negotiation");

endmodule : pmr_regs
`default_nettype wire

/* dv/pmr_line_model.sv */
// Purpose: far-side model, negotiation partner and line receive source
// Assumes: negotiation start is a one-cycle pulse
// Notes: ack delay is set by the bench, short or long
`timescale 1ns/1ps
`default_nettype none

module pmr_line_model (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic aneg_start_in,
    input wire logic [3:0] ack_delay_in,
    output logic aneg_ack_out,
    output logic [7:0] line_rxd_out,
    output logic line_rx_dv_out
);
    // ----------------------------------------
    // Negotiation answer
    // ----------------------------------------
    logic [3:0] wait_reg;

    // A restart drops a pending answer, as a real partner would
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wait_reg <= 4'h0;
            aneg_ack_out <= 1'b0;
        end else if (aneg_start_in) begin
            wait_reg <= ack_delay_in;
            aneg_ack_out <= 1'b0;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
            aneg_ack_out <= (wait_reg == 4'h1);
        end
    end

    // ----------------------------------------
    // Line receive traffic
    // ----------------------------------------
    // Changes every cycle so stale data never looks valid
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_rxd_out <= 8'h3C;
        end else begin
            line_rxd_out <= line_rxd_out + 8'h17;
        end
    end
    assign line_rx_dv_out = line_rxd_out[0];
endmodule : pmr_line_model
`default_nettype wire

/* dv/pmr_regs_tb.sv */
// Purpose: self-checking bench for the management register set
// Assumes: inputs change 1 ns after the rising edge
// Notes: expectations come from the reset and mask constants
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"

module pmr_regs_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr_s, rd_s, sticky, link, fault, jab, tx_en, rvalid, rx_dv, ltx_en, col, fdx, pdn;
    logic ack, astart, lrxdv;
    logic [7:0] txd, rxd, ltxd, lrxd;
    logic [3:0] ack_dly;
    logic [15:0] rdata, adv, rv;
    logic [1:0] speed;
    int n_fail = 0;
    int comparisons = 0;
    int n_start = 0;
    int mark;

    always #2 clock_in = ~clock_in;

    // Mid-cycle sampling keeps the pulse count race free
    always @(negedge clock_in) if (astart === 1'b1) n_start++;

    pmr_regs dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_wdata_in(wdata), .sticky_keep_in(sticky),
        .link_pass_in(link), .far_fault_in(fault), .jabber_in(jab), .aneg_ack_in(ack),
        .tx_en_in(tx_en), .txd_in(txd), .line_rxd_in(lrxd), .line_rx_dv_in(lrxdv),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .rxd_out(rxd), .rx_dv_out(rx_dv),
        .line_txd_out(ltxd), .line_tx_en_out(ltx_en), .col_out(col), .speed_out(speed),
        .full_duplex_out(fdx), .power_down_out(pdn), .aneg_start_out(astart),
        .advert_latched_out(adv));

    pmr_line_model partner_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .aneg_start_in(astart), .ack_delay_in(ack_dly), .aneg_ack_out(ack),
        .line_rxd_out(lrxd), .line_rx_dv_out(lrxdv));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc

    // A spare cycle after each strobe avoids re-raising it in the same step
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        cyc(1);
        wr_s = 1'b0;
        cyc(1);
    endtask : wr

    task automatic rdchk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e,
        input string nm);
        addr = a;
        rd_s = 1'b1;
        cyc(1);
        rd_s = 1'b0;
        rv = rdata;
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        chk(nm, e & m, rv & m);
        cyc(1);
    endtask : rdchk

    task automatic chk_start(input int n0);
        cyc(6);
        chk("aneg_start", 16'h0001, {15'h0000, n_start > n0});
    endtask : chk_start

    task automatic wait_col(input logic v, input int lim, input string nm);
        for (int i = 0; i < lim && col !== v; i++) cyc(1);
        chk(nm, {15'h0000, v}, {15'h0000, col});
    endtask : wait_col

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("reset start", 16'h0001, {15'h0000, n_start > 0});
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, `PMR_CONTROL_RESET, "control");
        rdchk(`PMR_OFS_STATUS, 16'hFFC9, `PMR_STATUS_FIXED, "status fixed");
        rdchk(`PMR_OFS_STATUS, 16'h0048, 16'h0048, "status caps");
        wr(`PMR_OFS_ID_LOW, 16'hFFFF);
        rdchk(`PMR_OFS_ID_LOW, 16'hFFFF, `PMR_OUI_LOW, "id low");
        rdchk(`PMR_OFS_ID_HIGH, 16'hFFFF, {`PMR_OUI_HIGH, `PMR_MODEL, `PMR_REVISION},
            "id high");
        rdchk(`PMR_OFS_ADVERT, 16'hFFFF, `PMR_ADVERT_RESET, "advert");
        rdchk(5'h07, 16'hFFFF, 16'h0000, "unmapped");
    endtask : t_reset

    // Forced 10 and 100 only; forced gigabit is checked in the loopback test
    task automatic t_forced();
        wr(`PMR_OFS_CONTROL, 16'h0000);
        cyc(1);
        chk("speed 10", 16'h0000, {14'h0000, speed});
        chk("half duplex", 16'h0000, {15'h0000, fdx});
        wr(`PMR_OFS_CONTROL, 16'h253F);
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, 16'h2100, "reserved ctl");
        chk("speed 100", 16'h0001, {14'h0000, speed});
        chk("full duplex", 16'h0001, {15'h0000, fdx});
    endtask : t_forced

    task automatic t_aneg();
        wr(`PMR_OFS_ADVERT, 16'h0C61);
        ack_dly = 4'hF;
        mark = n_start;
        wr(`PMR_OFS_CONTROL, 16'h3200);
        chk_start(mark);
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, 16'h3000, "restart clear");
        rdchk(`PMR_OFS_STATUS, 16'h0020, 16'h0000, "aneg busy");
        cyc(16);
        rdchk(`PMR_OFS_STATUS, 16'h0020, 16'h0020, "aneg done");
        chk("aneg speed", 16'h0002, {14'h0000, speed});
        chk("aneg duplex", 16'h0001, {15'h0000, fdx});
        chk("advert latched", 16'h0C61, adv);
        ack_dly = 4'h2;
    endtask : t_aneg

    task automatic t_softreset();
        wr(`PMR_OFS_CONTROL, 16'h2100);
        wr(`PMR_OFS_CONTROL, 16'h8000);
        cyc(12);
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, `PMR_CONTROL_RESET, "soft ctl");
        rdchk(`PMR_OFS_ADVERT, 16'hFFFF, `PMR_ADVERT_RESET, "soft advert");
        sticky = 1'b1;
        wr(`PMR_OFS_ADVERT, 16'h0021);
        wr(`PMR_OFS_CONTROL, 16'h8000);
        cyc(12);
        rdchk(`PMR_OFS_ADVERT, 16'hFFFF, 16'h0021, "sticky advert");
        sticky = 1'b0;
    endtask : t_softreset

    task automatic t_loop();
        wr(`PMR_OFS_CONTROL, 16'h50C0);
        tx_en = 1'b1;
        txd = 8'hA5;
        wait_col(1'b1, 3, "col rise");
        cyc(2);
        chk("loop rxd", 16'h00A5, {8'h00, rxd});
        chk("loop dv", 16'h0001, {15'h0000, rx_dv});
        chk("line quiet", 16'h0000, {15'h0000, ltx_en});
        chk("loop txd", 16'h0000, {8'h00, ltxd});
        chk("loop speed", 16'h0002, {14'h0000, speed});
        tx_en = 1'b0;
        wait_col(1'b0, 1, "col fall");
        wr(`PMR_OFS_CONTROL, 16'h1000);
        chk("line txd", 16'h00A5, {8'h00, ltxd});
        chk("line rxd", {8'h00, lrxd - 8'h17}, {8'h00, rxd});
        chk("line dv", {15'h0000, ~lrxdv}, {15'h0000, rx_dv});
    endtask : t_loop

    task automatic t_pdown();
        tx_en = 1'b1;
        wr(`PMR_OFS_CONTROL, 16'h1900);
        chk("power down", 16'h0001, {15'h0000, pdn});
        cyc(1);
        chk("pd line", 16'h0000, {15'h0000, ltx_en});
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, 16'h1900, "pd keep");
        tx_en = 1'b0;
        mark = n_start;
        wr(`PMR_OFS_CONTROL, 16'h1100);
        rdchk(`PMR_OFS_CONTROL, 16'hFFFF, 16'h1100, "pd exit");
        chk_start(mark);
    endtask : t_pdown

    task automatic t_latches();
        rdchk(`PMR_OFS_STATUS, 16'h0004, 16'h0000, "link down");
        link = 1'b1;
        cyc(2);
        rdchk(`PMR_OFS_STATUS, 16'h0004, 16'h0000, "link first");
        rdchk(`PMR_OFS_STATUS, 16'h0004, 16'h0004, "link up");
        link = 1'b0;
        cyc(2);
        link = 1'b1;
        cyc(2);
        rdchk(`PMR_OFS_STATUS, 16'h0004, 16'h0000, "link lost");
        wr(`PMR_OFS_CONTROL, 16'h0000);
        jab = 1'b1;
        cyc(1);
        jab = 1'b0;
        cyc(2);
        rdchk(`PMR_OFS_STATUS, 16'h0002, 16'h0002, "jabber set");
        rdchk(`PMR_OFS_STATUS, 16'h0002, 16'h0000, "jabber clr");
        fault = 1'b1;
        cyc(2);
        rdchk(`PMR_OFS_STATUS, 16'h0010, 16'h0010, "fault set");
        rdchk(`PMR_OFS_STATUS, 16'h0010, 16'h0010, "fault held");
        fault = 1'b0;
        cyc(2);
        rdchk(`PMR_OFS_STATUS, 16'h0010, 16'h0010, "fault latched");
        rdchk(`PMR_OFS_STATUS, 16'h0010, 16'h0000, "fault clr");
    endtask : t_latches

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        {addr, wdata, wr_s, rd_s, sticky, link, fault, jab, tx_en, txd} = '0;
        ack_dly = 4'h4;
        repeat (10) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        cyc(3);
        t_reset();
        t_forced();
        t_aneg();
        t_softreset();
        t_loop();
        t_pdown();
        t_latches();
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
endmodule : pmr_regs_tb
`default_nettype wire
